/* rtl/nrd_pkg.sv */
package nrd_pkg;
   // reset filter: minimum low time in oscillator periods
   localparam int RST_FILT_CYC = 5;
   localparam int RST_FILT_W = 3;
   // configuration bit positions
   localparam int CFG_SWRST_BIT = 7;
   localparam int CFG_TXJOIN_BIT = 5;
   localparam logic [7:0] CFG_RST_VAL = 8'h00;
   localparam logic [7:0] SETUP1_RST_VAL = 8'h00;
   localparam logic [7:0] STATION_RST_VAL = 8'h00;
   // self-write signature
   localparam logic [7:0] RAM_SIG_DATA = 8'hD1;
   localparam logic [10:0] RAM_SIG_ADDR = 11'h000;
   localparam logic [10:0] RAM_ID_ADDR = 11'h001;
   // nak limits
   localparam logic [6:0] NAK_LIMIT_LONG = 7'h7F;
   localparam logic [6:0] NAK_LIMIT_SHORT = 7'h03;
   // duplicate detection windows
   localparam real DUP_WIN_SHORT_S = 6.72;
   localparam real DUP_WIN_LONG_S = 13.44;
   localparam real CLK_MHZ = 250.0;
   localparam longint DUP_CYC_SHORT = longint'(DUP_WIN_SHORT_S * CLK_MHZ * 1.0e6);
   localparam longint DUP_CYC_LONG = longint'(DUP_WIN_LONG_S * CLK_MHZ * 1.0e6);

   typedef enum logic [1:0] {
      NRD_BUS_UNKNOWN = 2'b00,
      NRD_BUS_WR_SEEN = 2'b01,
      NRD_BUS_LOCKED = 2'b10
   } nrd_bus_st_t;

   typedef enum logic [1:0] {
      NRD_SIG_IDLE = 2'b00,
      NRD_SIG_WR0 = 2'b01,
      NRD_SIG_WR1 = 2'b10
   } nrd_sig_st_t;

   // observed token on the line, as decoded by the receiver
   typedef struct packed {
      logic valid;
      logic own;
      logic [7:0] dest;
   } nrd_token_t;

   // diagnostic status flags
   typedef struct packed {
      logic self_reconfig_flag;
      logic duplicate_station_flag;
      logic rx_activity_flag;
      logic token_seen;
      logic excess_nak_flag;
      logic probe_id_match;
      logic new_next_id;
   } nrd_diag_t;
endpackage

/* rtl/nrd_rst_filter.sv */
`timescale 1ns/10ps
module nrd_rst_filter
   import nrd_pkg::*;
#(
   parameter int CYC = RST_FILT_CYC
) (
   input wire logic mclk, // oscillator clock
   input wire logic hw_reset_in_n, // raw reset pin
   output logic rst_out // filtered reset, high active
);
   logic sync1_q;
   logic sync2_q;
   logic [RST_FILT_W-1:0] cnt_q;

   // two-flop synchroniser for the pin; nothing in the filter is reset at power-up
   always_ff @(posedge mclk) begin
      sync1_q <= hw_reset_in_n;
      sync2_q <= sync1_q;
   end

   // glitches shorter than the count are thrown away
   always_ff @(posedge mclk) begin
      if (sync2_q) begin
         cnt_q <= '0;
         rst_out <= 1'b0;
      end else if (cnt_q < RST_FILT_W'(CYC - 1)) begin
         cnt_q <= cnt_q + 1'b1;
      end else begin
         rst_out <= 1'b1;
      end
   end
endmodule

/* rtl/nrd_core.sv */
`timescale 1ns/10ps
module nrd_core
   import nrd_pkg::*;
#(
   parameter int NAK_W = 7,
   parameter longint DUP_SHORT = DUP_CYC_SHORT, // window counts, shorten in simulation
   parameter longint DUP_LONG = DUP_CYC_LONG
) (
   input wire logic mclk, // 250 MHz clock
   input wire logic rst_b, // sync reset, active low
   input wire logic hw_reset_in_n, // raw reset pin, filtered
   input wire logic cfg_wr, // config register write strobe
   input wire logic [7:0] cfg_wdata, // config write data
   input wire logic setup1_wr, // setup1 write strobe
   input wire logic [7:0] setup1_wdata, // setup1 data, bit 1 is short_nak_limit
   input wire logic station_wr, // station id write strobe
   input wire logic [7:0] station_wdata, // station id data
   input wire logic probe_wr, // probe id write strobe
   input wire logic [7:0] probe_wdata, // probe id data
   input wire logic host_wr, // host write cycle
   input wire logic host_rd, // host read cycle
   input wire logic host_a0, // host address bit 0
   input wire logic host_bus_type, // bus style sampled on odd write
   input wire logic diag_rd, // diagnostic status read strobe
   input wire logic clr_flags_cmd, // clear-flags command
   input wire logic dis_tx_cmd, // disable-transmitter command
   input wire logic en_tx_cmd, // enable-transmit command
   input wire logic line_rx_in, // line receive input
   input wire nrd_token_t token_in, // observed token
   input wire logic token_resp, // response seen to observed token
   input wire logic token_to_me, // token passed to this node
   input wire logic reconfig_event_timer_exp, // own token reception timer expired
   input wire logic reconfig_event_seen, // reconfiguration seen on line
   input wire logic nak_rx, // nak answering our free-buffer enquiry
   input wire logic [7:0] next_id_in, // current next logical node
   input wire logic timeout_sel_0, // timeout select 0
   input wire logic timeout_sel_1, // timeout select 1
   output logic [7:0] cfg_q, // configuration register
   output logic [7:0] setup1_q, // setup1 register
   output logic [7:0] station_id_q, // station id register
   output logic core_awake_q, // core runs microcode
   output logic join_ok_q, // node may join network
   output logic tx_enabled_q, // transmitter section enabled
   output logic tx_available_q, // transmitter available
   output logic bus_locked_q, // bus type determined
   output logic bus_type_q, // determined bus type
   output logic ram_we_q, // buffer ram write strobe
   output logic [10:0] ram_addr_q, // buffer ram address
   output logic [7:0] ram_wdata_q, // buffer ram data
   output nrd_diag_t diag_q, // diagnostic flags
   output logic reconfig_event_q, // main status reconfig bit
   output logic irq_q, // interrupt request
   output logic int_rst_q // internal reset active
);
   logic hw_rst;
   logic sw_rst;
   logic any_rst;
   logic short_nak_limit;
   logic [7:0] probe_q;
   logic [7:0] next_id_q;
   logic [NAK_W-1:0] nak_cnt_q;
   logic [NAK_W-1:0] nak_limit;
   logic [39:0] dup_cnt_q;
   logic [39:0] dup_win;
   logic dis_pend_q;
   nrd_bus_st_t bus_st_q;
   nrd_sig_st_t sig_st_q;

   nrd_rst_filter #(.CYC(RST_FILT_CYC)) u_filt (
      .mclk(mclk),
      .hw_reset_in_n(hw_reset_in_n),
      .rst_out(hw_rst)
   );

   assign sw_rst = cfg_q[CFG_SWRST_BIT];
   assign any_rst = !rst_b || hw_rst || sw_rst;
   assign short_nak_limit = setup1_q[1];
   assign nak_limit = short_nak_limit ? NAK_W'(NAK_LIMIT_SHORT) : NAK_W'(NAK_LIMIT_LONG);
   assign dup_win = (timeout_sel_0 && timeout_sel_1) ? 40'(DUP_SHORT) : 40'(DUP_LONG);

   ////////////////////////////////////////////////////////////////////////////
   // reset status
   always_ff @(posedge mclk) begin
      int_rst_q <= any_rst;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers kept across software reset; only hard reset clears them
   always_ff @(posedge mclk) begin
      if (!rst_b || hw_rst) begin
         cfg_q <= CFG_RST_VAL;
         setup1_q <= SETUP1_RST_VAL;
      end else begin
         if (cfg_wr) begin
            cfg_q <= cfg_wdata;
         end
         if (setup1_wr && !sw_rst) begin
            setup1_q <= setup1_wdata;
         end
      end
   end

   // bus type: odd write then odd read; survives software reset
   always_ff @(posedge mclk) begin
      if (!rst_b || hw_rst) begin
         bus_st_q <= NRD_BUS_UNKNOWN;
         bus_locked_q <= 1'b0;
         bus_type_q <= 1'b0;
      end else begin
         case (bus_st_q)
            NRD_BUS_UNKNOWN: begin
               if (host_wr && host_a0) begin
                  bus_st_q <= NRD_BUS_WR_SEEN;
                  bus_type_q <= host_bus_type;
               end
            end
            NRD_BUS_WR_SEEN: begin
               if (host_rd && host_a0) begin
                  bus_st_q <= NRD_BUS_LOCKED;
                  bus_locked_q <= 1'b1;
               end
            end
            NRD_BUS_LOCKED: begin
               bus_locked_q <= 1'b1;
            end
            default: begin
               bus_st_q <= NRD_BUS_UNKNOWN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // station id, wake and join
   always_ff @(posedge mclk) begin
      if (any_rst) begin
         station_id_q <= STATION_RST_VAL;
         probe_q <= 8'h00;
         core_awake_q <= 1'b0;
         join_ok_q <= 1'b0;
      end else begin
         if (station_wr) begin
            station_id_q <= station_wdata;
         end
         if (probe_wr) begin
            probe_q <= probe_wdata;
         end
         core_awake_q <= (station_id_q != 8'h00);
         join_ok_q <= core_awake_q && cfg_q[CFG_TXJOIN_BIT];
      end
   end

   // self-write signature into buffer ram
   always_ff @(posedge mclk) begin
      if (any_rst) begin
         sig_st_q <= NRD_SIG_IDLE;
         ram_we_q <= 1'b0;
         ram_addr_q <= 11'h000;
         ram_wdata_q <= 8'h00;
      end else begin
         ram_we_q <= 1'b0;
         case (sig_st_q)
            NRD_SIG_IDLE: begin
               if (station_wr) begin
                  sig_st_q <= NRD_SIG_WR0;
               end
            end
            NRD_SIG_WR0: begin
               ram_we_q <= 1'b1;
               ram_addr_q <= RAM_SIG_ADDR;
               ram_wdata_q <= RAM_SIG_DATA;
               sig_st_q <= NRD_SIG_WR1;
            end
            NRD_SIG_WR1: begin
               ram_we_q <= 1'b1;
               ram_addr_q <= RAM_ID_ADDR;
               ram_wdata_q <= station_id_q;
               sig_st_q <= NRD_SIG_IDLE;
            end
            default: begin
               sig_st_q <= NRD_SIG_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter
   always_ff @(posedge mclk) begin
      if (any_rst) begin
         tx_enabled_q <= 1'b0;
         tx_available_q <= 1'b1;
         dis_pend_q <= 1'b0;
      end else begin
         tx_enabled_q <= join_ok_q;
         if (en_tx_cmd) begin
            tx_available_q <= 1'b0;
         end
         if (dis_tx_cmd && !tx_available_q) begin
            dis_pend_q <= 1'b1;
         end else if (dis_pend_q && token_to_me) begin
            dis_pend_q <= 1'b0;
            tx_available_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // duplicate id window; a response to a token for our id sets the flag
   always_ff @(posedge mclk) begin
      if (any_rst || station_wr) begin
         dup_cnt_q <= 40'h0;
      end else if (core_awake_q && dup_cnt_q < dup_win) begin
         dup_cnt_q <= dup_cnt_q + 40'h1;
      end
   end

   // flags: a set in the same cycle as a clear wins
   always_ff @(posedge mclk) begin
      if (any_rst) begin
         diag_q <= '0;
         next_id_q <= 8'h00;
      end else begin
         next_id_q <= next_id_in;
         if (reconfig_event_timer_exp && join_ok_q) begin
            diag_q.self_reconfig_flag <= 1'b1;
         end else if (diag_rd) begin
            diag_q.self_reconfig_flag <= 1'b0;
         end
         if (core_awake_q && token_in.valid && !token_in.own && token_resp
             && token_in.dest == station_id_q && dup_cnt_q < dup_win) begin
            diag_q.duplicate_station_flag <= 1'b1;
         end else if (diag_rd) begin
            diag_q.duplicate_station_flag <= 1'b0;
         end
         if (line_rx_in) begin
            diag_q.rx_activity_flag <= 1'b1;
         end
         if (token_in.valid && !token_in.own) begin
            diag_q.token_seen <= 1'b1;
         end
         if (token_in.valid && token_resp && token_in.dest == probe_q) begin
            diag_q.probe_id_match <= 1'b1;
         end else if (probe_wr) begin
            diag_q.probe_id_match <= 1'b0;
         end
         if (nak_rx && nak_cnt_q == nak_limit) begin
            diag_q.excess_nak_flag <= 1'b1;
         end else if (clr_flags_cmd) begin
            diag_q.excess_nak_flag <= 1'b0;
         end
         if (next_id_in != next_id_q && core_awake_q) begin
            diag_q.new_next_id <= 1'b1;
         end else if (diag_rd) begin
            diag_q.new_next_id <= 1'b0;
         end
      end
   end

   // nak counter wraps at the limit so the flag recurs every full count
   always_ff @(posedge mclk) begin
      if (any_rst || en_tx_cmd) begin
         nak_cnt_q <= '0;
      end else if (nak_rx) begin
         nak_cnt_q <= (nak_cnt_q == nak_limit) ? '0 : nak_cnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reconfiguration status and interrupt; clear-flags acknowledges
   always_ff @(posedge mclk) begin
      if (any_rst) begin
         reconfig_event_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         if (reconfig_event_seen || (reconfig_event_timer_exp && join_ok_q)) begin
            reconfig_event_q <= 1'b1;
         end else if (clr_flags_cmd) begin
            reconfig_event_q <= 1'b0;
         end
         irq_q <= reconfig_event_q || diag_q.excess_nak_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sw_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      sw_rst |=> int_rst_q && !tx_enabled_q)
      else $error("software reset not held");

   sequence sig_first;
      ram_we_q && ram_addr_q == RAM_SIG_ADDR && ram_wdata_q == RAM_SIG_DATA;
   endsequence
   sequence sig_second;
      ram_we_q && ram_addr_q == RAM_ID_ADDR && ram_wdata_q == station_id_q;
   endsequence
   sig_write_a: assert property (@(posedge mclk) disable iff (any_rst)
      station_wr && sig_st_q == NRD_SIG_IDLE |=> ##1 sig_first ##1 sig_second)
      else $error("signature writes wrong");

   asleep_a: assert property (@(posedge mclk) disable iff (!rst_b)
      station_id_q == 8'h00 |=> !core_awake_q ##1 !join_ok_q ##1 !tx_enabled_q)
      else $error("core active with zero id");

   join_gate_a: assert property (@(posedge mclk) disable iff (any_rst)
      join_ok_q |-> $past(cfg_q[CFG_TXJOIN_BIT]))
      else $error("joined without enable");

   diag_clr_a: assert property (@(posedge mclk) disable iff (any_rst)
      diag_rd && !reconfig_event_timer_exp && !token_resp |=>
         !diag_q.self_reconfig_flag && !diag_q.duplicate_station_flag)
      else $error("diag read did not clear");

   rx_act_a: assert property (@(posedge mclk) disable iff (any_rst)
      line_rx_in |=> diag_q.rx_activity_flag)
      else $error("rx activity missed");

   own_tok_a: assert property (@(posedge mclk) disable iff (any_rst)
      $rose(diag_q.token_seen) |-> $past(token_in.valid && !token_in.own))
      else $error("token flag from own token");

   nak_lim_a: assert property (@(posedge mclk) disable iff (any_rst)
      $rose(diag_q.excess_nak_flag) |-> $past(nak_cnt_q) == $past(nak_limit)
         ##1 irq_q)
      else $error("nak flag at wrong count");

   tx_avail_a: assert property (@(posedge mclk) disable iff (any_rst)
      dis_pend_q && token_to_me && !dis_tx_cmd |=> tx_available_q && !dis_pend_q)
      else $error("tx available not restored");

   reconfig_event_irq_a: assert property (@(posedge mclk) disable iff (any_rst)
      reconfig_event_seen |=> reconfig_event_q ##1 irq_q)
      else $error("reconfig interrupt missing");
endmodule

/* sim/nrd_line_model.sv */
`timescale 1ns/10ps
module nrd_line_model
   import nrd_pkg::*;
(
   input wire logic mclk, // oscillator clock
   output nrd_token_t token_in, // decoded token
   output logic token_resp, // response after token
   output logic nak_rx, // nak to our enquiry
   output logic line_rx_in // receive line level
);
   initial begin
      token_in = '0;
      token_resp = 1'b0;
      nak_rx = 1'b0;
      line_rx_in = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // outside valid the fields are flipped, so a design reading them there sees garbage
   task automatic tok(input logic [7:0] d, input logic own, input logic resp);
      token_in = '{valid: 1'b1, own: own, dest: d};
      token_resp = resp;
      @(negedge mclk);
      token_in = '{valid: 1'b0, own: ~own, dest: ~d};
      token_resp = ~resp;
      // one idle cycle, so back-to-back tokens never overwrite valid in one step
      @(negedge mclk);
   endtask
   task automatic naks(input int n);
      repeat (n) begin
         nak_rx = 1'b1;
         @(negedge mclk);
         nak_rx = 1'b0;
         @(negedge mclk);
      end
   endtask
   task automatic rx(input logic lvl);
      line_rx_in = lvl;
   endtask
endmodule

/* sim/test_nrd_core.sv */
`timescale 1ns/10ps
module test_nrd_core;
   import nrd_pkg::*;
   logic mclk = 1'b0;
   logic rst_b, hw_reset_in_n, cfg_wr, setup1_wr, station_wr, probe_wr, host_wr, host_rd;
   logic host_a0, host_bus_type, diag_rd, clr_flags_cmd, dis_tx_cmd, en_tx_cmd, seen;
   logic token_to_me, reconfig_event_timer_exp, reconfig_event_seen, timeout_sel_0, timeout_sel_1;
   logic line_rx_in, token_resp, nak_rx, core_awake_q, join_ok_q, tx_enabled_q;
   logic tx_available_q, bus_locked_q, bus_type_q, ram_we_q, reconfig_event_q, irq_q, int_rst_q;
   logic [7:0] cfg_wdata, setup1_wdata, station_wdata, probe_wdata, next_id_in;
   logic [7:0] cfg_q, setup1_q, station_id_q, ram_wdata_q;
   logic [10:0] ram_addr_q;
   logic [18:0] ram_exp[$];
   nrd_token_t token_in;
   nrd_diag_t diag_q;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 92;

   always #2 mclk = ~mclk;

   nrd_core #(.DUP_SHORT(50), .DUP_LONG(100)) u_dut (
      .mclk(mclk), .rst_b(rst_b), .hw_reset_in_n(hw_reset_in_n), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .setup1_wr(setup1_wr), .setup1_wdata(setup1_wdata),
      .station_wr(station_wr), .station_wdata(station_wdata), .probe_wr(probe_wr),
      .probe_wdata(probe_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_a0(host_a0),
      .host_bus_type(host_bus_type), .diag_rd(diag_rd), .clr_flags_cmd(clr_flags_cmd),
      .dis_tx_cmd(dis_tx_cmd), .en_tx_cmd(en_tx_cmd), .line_rx_in(line_rx_in),
      .token_in(token_in), .token_resp(token_resp), .token_to_me(token_to_me),
      .reconfig_event_timer_exp(reconfig_event_timer_exp), .reconfig_event_seen(reconfig_event_seen), .nak_rx(nak_rx),
      .next_id_in(next_id_in), .timeout_sel_0(timeout_sel_0), .timeout_sel_1(timeout_sel_1),
      .cfg_q(cfg_q), .setup1_q(setup1_q), .station_id_q(station_id_q),
      .core_awake_q(core_awake_q), .join_ok_q(join_ok_q), .tx_enabled_q(tx_enabled_q),
      .tx_available_q(tx_available_q), .bus_locked_q(bus_locked_q), .bus_type_q(bus_type_q),
      .ram_we_q(ram_we_q), .ram_addr_q(ram_addr_q), .ram_wdata_q(ram_wdata_q),
      .diag_q(diag_q), .reconfig_event_q(reconfig_event_q), .irq_q(irq_q),
      .int_rst_q(int_rst_q));

   nrd_line_model u_line (.mclk(mclk), .token_in(token_in), .token_resp(token_resp),
      .nak_rx(nak_rx), .line_rx_in(line_rx_in));

   ////////////////////////////////////////////////////////////////////////////////
   task stop_test;
      if (bad_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
      checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
   endtask
   task automatic wr(ref logic s, ref logic [7:0] w, input logic [7:0] v);
      w = v;
      pulse(s);
      cy(3);
   endtask
   // the model queues both signature writes before the strobe goes out
   task automatic sid(input logic [7:0] v);
      ram_exp.push_back({RAM_SIG_ADDR, RAM_SIG_DATA});
      ram_exp.push_back({RAM_ID_ADDR, v});
      wr(station_wr, station_wdata, v);
   endtask

   always @(negedge mclk) begin
      logic [18:0] e;
      if (ram_we_q === 1'b1) begin
         if (ram_exp.size() == 0) chk("ram_extra", 11'h000, 11'h7FF);
         else begin
            e = ram_exp.pop_front();
            chk("ram_addr", e[18:8], ram_addr_q);
            chk("ram_data", 11'(e[7:0]), 11'(ram_wdata_q));
         end
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {cfg_wr, setup1_wr, station_wr, probe_wr, host_wr, host_rd, host_a0, host_bus_type} = '0;
      {diag_rd, clr_flags_cmd, dis_tx_cmd, en_tx_cmd, token_to_me, reconfig_event_timer_exp} = '0;
      {cfg_wdata, setup1_wdata, station_wdata, probe_wdata, next_id_in} = '0;
      {timeout_sel_0, timeout_sel_1} = 2'b11;
      reconfig_event_seen = 1'b0;
      hw_reset_in_n = 1'b1;
      rst_b = 1'b0;
      cy(6);
      rst_b = 1'b1;
      cy(2);
      chk("cfg", 11'(CFG_RST_VAL), 11'(cfg_q));
      chk("setup1", 11'(SETUP1_RST_VAL), 11'(setup1_q));
      chk("ta_diag", 11'h400, {tx_available_q, 2'h0, tx_enabled_q, diag_q});
      pulse(reconfig_event_timer_exp);
      cy(3);
      chk("asleep", 11'h000, 11'({core_awake_q, diag_q.self_reconfig_flag}));
      host_bus_type = 1'b1;
      pulse(host_wr);
      pulse(host_rd);
      cy(2);
      chk("even_lock", 11'h000, 11'(bus_locked_q));
      host_a0 = 1'b1;
      pulse(host_wr);
      host_bus_type = 1'b0;
      pulse(host_rd);
      cy(2);
      chk("bus", 11'h003, 11'({bus_locked_q, bus_type_q}));
      wr(setup1_wr, setup1_wdata, 8'h02);
      sid(8'h5A);
      chk("awake_join", 11'h002, 11'({core_awake_q, join_ok_q}));
      chk("rx_idle", 11'h000, 11'(diag_q.rx_activity_flag));
      u_line.rx(1'b1);
      cy(2);
      u_line.rx(1'b0);
      chk("rx_act", 11'h001, 11'(diag_q.rx_activity_flag));
      repeat (8) u_line.tok(8'($random(seed)), 1'b1, 1'b0);
      cy(2);
      chk("tok_own", 11'h000, 11'(diag_q.token_seen));
      u_line.tok(8'($random(seed)), 1'b0, 1'b0);
      cy(2);
      chk("tok_seen", 11'h001, 11'(diag_q.token_seen));
      cy(60);
      u_line.tok(8'h5A, 1'b0, 1'b1);
      cy(2);
      chk("dup_short", 11'h000, 11'(diag_q.duplicate_station_flag));
      {timeout_sel_0, timeout_sel_1} = 2'b00;
      sid(8'h5A);
      cy(60);
      u_line.tok(8'h5B, 1'b0, 1'b1);
      u_line.tok(8'h5A, 1'b0, 1'b0);
      cy(2);
      chk("dup_miss", 11'h000, 11'(diag_q.duplicate_station_flag));
      u_line.tok(8'h5A, 1'b0, 1'b1);
      cy(2);
      chk("dup_long", 11'h001, 11'(diag_q.duplicate_station_flag));
      pulse(reconfig_event_seen);
      cy(2);
      chk("reconfig_event_line", 11'h003, 11'({diag_q.self_reconfig_flag, reconfig_event_q, irq_q}));
      pulse(clr_flags_cmd);
      wr(cfg_wr, cfg_wdata, 8'h20);
      chk("join_en", 11'h001, 11'(join_ok_q));
      pulse(reconfig_event_timer_exp);
      cy(3);
      chk("reconfig_event", 11'h007, 11'({diag_q.self_reconfig_flag, reconfig_event_q, irq_q}));
      pulse(diag_rd);
      cy(2);
      chk("diag_clr", 11'h000, 11'({diag_q.self_reconfig_flag, diag_q.duplicate_station_flag}));
      // a repeated self-reconfig flag is the host's cue to take the transmitter down
      pulse(reconfig_event_timer_exp);
      cy(2);
      chk("reconfig_event_again", 11'h001, 11'(diag_q.self_reconfig_flag));
      pulse(dis_tx_cmd);
      pulse(clr_flags_cmd);
      cy(2);
      chk("irq_clr", 11'h000, 11'(irq_q));
      probe_wdata = 8'h33;
      pulse(probe_wr);
      u_line.tok(8'h34, 1'b0, 1'b1);
      cy(2);
      chk("probe_miss", 11'h000, 11'(diag_q.probe_id_match));
      u_line.tok(8'h33, 1'b0, 1'b1);
      cy(2);
      chk("probe_hit", 11'h001, 11'(diag_q.probe_id_match));
      next_id_in = 8'h10;
      cy(3);
      chk("next_id", 11'h001, 11'(diag_q.new_next_id));
      // same four-nak limit twice: the wrapped counter must need a full count again
      repeat (2) begin
         for (int i = 1; i <= 4; i++) begin
            u_line.naks(1);
            chk("nak4", 11'(i == 4), 11'(diag_q.excess_nak_flag));
         end
         chk("nak_irq", 11'h001, 11'(irq_q));
         pulse(clr_flags_cmd);
         cy(1);
         chk("nak_clr", 11'h000, 11'(diag_q.excess_nak_flag));
      end
      pulse(en_tx_cmd);
      wr(setup1_wr, setup1_wdata, 8'h00);
      for (int i = 1; i <= 128; i++) begin
         u_line.naks(1);
         chk("nak128", 11'(i == 128), 11'(diag_q.excess_nak_flag));
      end
      pulse(dis_tx_cmd);
      cy(2);
      chk("ta_wait", 11'h000, 11'(tx_available_q));
      pulse(token_to_me);
      cy(2);
      chk("ta_token", 11'h001, 11'(tx_available_q));
      wr(setup1_wr, setup1_wdata, 8'h02);
      wr(cfg_wr, cfg_wdata, 8'hA0);
      chk("swrst", 11'h4A0, {int_rst_q, 2'b00, cfg_q});
      chk("keep", 11'h013, {setup1_q, 1'b0, bus_locked_q, bus_type_q});
      chk("dflt", 11'h000, {station_id_q, tx_enabled_q, core_awake_q, 1'b0});
      wr(setup1_wr, setup1_wdata, 8'h00);
      chk("sw_hold", 11'h402, {int_rst_q, 2'b00, setup1_q});
      wr(cfg_wr, cfg_wdata, 8'h00);
      chk("sw_end", 11'h000, 11'(int_rst_q));
      for (int i = 0; i < 14; i++) begin
         hw_reset_in_n = (i >= 4);
         cy(1);
         chk("glitch", 11'h000, 11'(int_rst_q));
      end
      seen = 1'b0;
      for (int i = 0; i < 14; i++) begin
         hw_reset_in_n = (i >= 5);
         cy(1);
         seen = seen | (int_rst_q === 1'b1);
      end
      chk("hw_rst", 11'h001, 11'(seen));
      cy(10);
      chk("hw_dflt", 11'h000, {2'b00, cfg_q, bus_locked_q});
      chk("ram_left", 11'h000, 11'(ram_exp.size()));
      stop_test();
   end
endmodule
